// ==== design/ucse_consts.svh ====
/*
  register offsets, field positions, reset values and counts for the
  checksum / smart card event block.
  assumes a 32-bit apb bus with byte addresses, one word per register.
*/
// Contract
// [RL1] lin, include set: sum all bytes with pid
// [RL2] lin, include clear: sum data, skip pid
// [RL3] lin slave modes: break clears checksum
// [RL4] non-lin, include set: sum every byte
// [RL5] non-lin, include clear: checksum untouched
// [RL6] repeat field sets one to four retransmits
// [RL7] convention bit: 1 inverse, 0 direct
// [RL8] t0 error pulldown: two or one etu
// [RL9] protocol bit: 1 is t1, 0 t0
// [RL10] rx repeat flag after five bad receptions
// [RL11] tx repeat flag after last retransmit fails
// [RL12] block time flag when counter hits zero
// [RL13] waiting time flag when counter hits zero
// [RL14] guard time flag when counter hits zero
// [RL15] each card event gated by own enable
// [RL16] flags set by hardware, cleared by software
// [RL17] wake enabled: rx falling edge sets flag
// [RL18] autobaud final falling edge sets done flag
// [RL19] autobaud done interrupts only when enabled
// [RL20] unimplemented bits read zero, reset zero
// [RL21] guard and block counters tick per etu
`ifndef UCSE_CONSTS_SVH
`define UCSE_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UCSE_OFS_RX_CHECKSUM     12'h000
`define UCSE_OFS_SC_CONFIG       12'h004
`define UCSE_OFS_SC_EVENT_CTRL   12'h008
`define UCSE_OFS_WAKE_ABD_CTRL   12'h00C

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define UCSE_MASK_RX_CHECKSUM    16'h00FF
`define UCSE_MASK_SC_CONFIG      16'h003E
`define UCSE_MASK_SC_EVENT_CTRL  16'h3737
`define UCSE_MASK_WAKE_ABD_CTRL  16'h00C4
`define UCSE_RESET_VALUE         16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define UCSE_BIT_RETRANSMIT_COUNT_SELECT_LO        4
`define UCSE_BIT_LOGIC_CONVENTION_SELECT            3
`define UCSE_BIT_PULLDOWN        2
`define UCSE_BIT_PROTOCOL        1
`define UCSE_BIT_RXRPT_FLAG      13
`define UCSE_BIT_RETRANSMIT_COUNT_SELECT_FLAG      12
`define UCSE_BIT_BLOCK_FLAG      10
`define UCSE_BIT_WAIT_FLAG       9
`define UCSE_BIT_GUARD_FLAG      8
`define UCSE_BIT_WAKE_FLAG       7
`define UCSE_BIT_ABD_FLAG        6
`define UCSE_BIT_ABD_ENABLE      2

// ----------------------------------------
// counts
// ----------------------------------------
`define UCSE_RX_RECEPTIONS_MAX   3'h5
`define UCSE_ABD_FALL_EDGES      3'h5
`define UCSE_TIMER_COUNT         3

`endif

// ==== design/ucse_pkg.sv ====
/*
  types shared by the checksum / smart card event block.
  assumes the constants header is included alongside.
*/
package ucse_pkg;

  typedef logic [15:0] ucse_reg_t;

  // gray-coded apb slave phase
  typedef enum logic [1:0] {
    UCSE_IDLE   = 2'b00,
    UCSE_ANSWER = 2'b01
  } ucse_phase_t;

endpackage

// ==== design/ucse_top.sv ====
/*
  apb register block with receive checksum, smart card settings and
  smart card / wake-up / auto-baud event flags.
  assumes the byte receiver, mode registers and etu tick come from
  neighbouring logic on pclk; only rx_pin arrives asynchronously.
*/
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ucse_consts.svh"

module ucse_top #(
  parameter int TIMER_W = 24
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               lin_mode,
  input  wire logic               lin_slave_mode,
  input  wire logic               checksum_include_select,
  input  wire logic               break_detect,
  input  wire logic               rx_byte_valid,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_byte_is_pid,
  input  wire logic               smart_card_mode,
  input  wire logic               rx_char_done,
  input  wire logic               rx_parity_error,
  input  wire logic               tx_char_done,
  input  wire logic               tx_line_error,
  input  wire logic               etu_tick,
  input  wire logic [2:0]         timer_start,
  input  wire logic [TIMER_W-1:0] guard_load,
  input  wire logic [TIMER_W-1:0] block_load,
  input  wire logic [TIMER_W-1:0] waiting_load,
  input  wire logic               wake_enable,
  input  wire logic               autobaud_enable,
  input  wire logic               rx_pin,
  output logic                    tx_retransmit,
  output logic                    card_line_pulldown,
  output logic                    logic_convention_inverse,
  output logic                    card_protocol_t1,
  output logic                    smart_card_irq,
  output logic                    event_irq
);
  import ucse_pkg::*;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  ucse_phase_t phase_q;
  ucse_phase_t phase_d;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        pready_q;
  ucse_reg_t   rdata_mux;
  logic        addr_hit;
  logic        wr_fire;
  logic        setup_cyc;
  logic        lo_en;
  logic        hi_en;
  wire         sel_chk = (paddr == `UCSE_OFS_RX_CHECKSUM);
  wire         sel_cfg = (paddr == `UCSE_OFS_SC_CONFIG);
  wire         sel_sci = (paddr == `UCSE_OFS_SC_EVENT_CTRL);
  wire         sel_int = (paddr == `UCSE_OFS_WAKE_ABD_CTRL);

  assign addr_hit  = sel_chk | sel_cfg | sel_sci | sel_int;
  assign setup_cyc = psel & ~penable & (phase_q == UCSE_IDLE);
  // no wait state: pready rises in the first access cycle
  assign phase_d   = setup_cyc ? UCSE_ANSWER : UCSE_IDLE;
  assign wr_fire   = psel & penable & pwrite & (phase_q == UCSE_ANSWER) & addr_hit;
  assign lo_en     = pstrb[0];
  assign hi_en     = pstrb[1];

  // byte-lane merge restricted to the implemented bits
  function automatic ucse_reg_t merge(input ucse_reg_t old_v, input ucse_reg_t mask,
                                      input logic [15:0] wd, input logic le,
                                      input logic he);
    ucse_reg_t m;
    m = mask & {{8{he}}, {8{le}}};
    merge = (old_v & ~m) | (wd & m);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= UCSE_IDLE;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      pslverr_q <= setup_cyc & ~addr_hit;
      // pready from its own flop so the bus never sees decode glitches
      pready_q  <= setup_cyc;
      if (setup_cyc) begin
        prdata_q <= {16'h0000, rdata_mux};
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // receive checksum
  // ----------------------------------------
  logic [7:0] chk_q;
  logic [7:0] chk_d;
  logic [8:0] chk_sum;
  logic       chk_add;
  logic       chk_lin_add;
  ucse_reg_t  chk_wr;

  // in lin modes the include bit only decides whether the pid counts
  assign chk_lin_add = checksum_include_select | ~rx_byte_is_pid; // RL1 RL2
  assign chk_add     = rx_byte_valid & (lin_mode ? chk_lin_add
                                                 : checksum_include_select); // RL4 RL5
  assign chk_sum     = {1'b0, chk_q} + {1'b0, rx_byte};
  assign chk_wr      = merge({8'h00, chk_q}, `UCSE_MASK_RX_CHECKSUM, pwdata[15:0],
                             lo_en, hi_en);

  always_comb begin
    chk_d = chk_q;
    if (wr_fire & sel_chk) begin
      chk_d = chk_wr[7:0];
    end
    if (chk_add) begin
      chk_d = chk_sum[7:0] + {7'h00, chk_sum[8]}; // RL1
    end
    if (lin_slave_mode & break_detect) begin
      chk_d = 8'h00; // RL3
    end
  end

  // ----------------------------------------
  // smart card configuration
  // ----------------------------------------
  ucse_reg_t cfg_q;
  logic [1:0] retransmit_count_select;

  assign retransmit_count_select = cfg_q[`UCSE_BIT_RETRANSMIT_COUNT_SELECT_LO +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q <= 8'h00;
      cfg_q <= `UCSE_RESET_VALUE; // RL20
    end else begin
      chk_q <= chk_d;
      if (wr_fire & sel_cfg) begin
        cfg_q <= merge(cfg_q, `UCSE_MASK_SC_CONFIG, pwdata[15:0], lo_en, hi_en);
      end
    end
  end

  // ----------------------------------------
  // repeat tracking
  // ----------------------------------------
  logic [2:0] rx_tries_q;
  logic [2:0] tx_tries_q;
  logic       rx_rpt_set;
  logic       tx_rpt_set;
  logic       tx_retry;
  logic       tx_retransmit_q;

  // five receptions of one character all carrying parity errors
  assign rx_rpt_set = smart_card_mode & rx_char_done & rx_parity_error &
                      (rx_tries_q == `UCSE_RX_RECEPTIONS_MAX - 3'h1); // RL10
  // retransmit_count_select 00 allows one retransmit, 11 allows four
  assign tx_rpt_set = smart_card_mode & tx_char_done & tx_line_error &
                      (tx_tries_q == {1'b0, retransmit_count_select} + 3'h1); // RL6 RL11
  assign tx_retry   = smart_card_mode & tx_char_done & tx_line_error & ~tx_rpt_set; // RL6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tries_q      <= 3'h0;
      tx_tries_q      <= 3'h0;
      tx_retransmit_q <= 1'b0;
    end else begin
      tx_retransmit_q <= tx_retry;
      if (rx_char_done) begin
        rx_tries_q <= (rx_parity_error & ~rx_rpt_set) ? rx_tries_q + 3'h1 : 3'h0;
      end
      if (tx_char_done) begin
        tx_tries_q <= tx_retry ? tx_tries_q + 3'h1 : 3'h0;
      end
    end
  end

  // ----------------------------------------
  // t0 error pulldown
  // ----------------------------------------
  logic [1:0] pd_left_q;
  logic       pd_start;

  // only the t0 protocol signals a character error on the line
  assign pd_start = smart_card_mode & ~cfg_q[`UCSE_BIT_PROTOCOL] & rx_char_done &
                    rx_parity_error; // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_left_q <= 2'h0;
    end else if (pd_start) begin
      pd_left_q <= cfg_q[`UCSE_BIT_PULLDOWN] ? 2'h2 : 2'h1; // RL8
    end else if (etu_tick & (pd_left_q != 2'h0)) begin
      pd_left_q <= pd_left_q - 2'h1; // RL8
    end
  end

  // ----------------------------------------
  // guard, waiting and block time counters
  // ----------------------------------------
  logic [TIMER_W-1:0] tmr_load [`UCSE_TIMER_COUNT];
  logic [2:0]         tmr_zero;

  assign tmr_load[0] = guard_load;
  assign tmr_load[1] = waiting_load;
  assign tmr_load[2] = block_load;

  genvar gi;
  generate
    for (gi = 0; gi < `UCSE_TIMER_COUNT; gi++) begin : g_tmr
      logic [TIMER_W-1:0] cnt_q;
      logic               run_q;
      // the zero event is the tick that takes the count from one to zero
      assign tmr_zero[gi] = run_q & etu_tick & (cnt_q == {{(TIMER_W-1){1'b0}}, 1'b1});
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= '0;
          run_q <= 1'b0;
        end else if (timer_start[gi]) begin
          cnt_q <= tmr_load[gi];
          run_q <= (tmr_load[gi] != '0);
        end else if (run_q & etu_tick) begin
          cnt_q <= cnt_q - {{(TIMER_W-1){1'b0}}, 1'b1}; // RL21
          run_q <= ~tmr_zero[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // smart card event flags and enables
  // ----------------------------------------
  ucse_reg_t sci_q;
  ucse_reg_t sci_d;
  ucse_reg_t sci_set;
  ucse_reg_t sci_wr;

  always_comb begin
    sci_set = 16'h0000;
    sci_set[`UCSE_BIT_RXRPT_FLAG] = rx_rpt_set;  // RL10
    sci_set[`UCSE_BIT_RETRANSMIT_COUNT_SELECT_FLAG] = tx_rpt_set;  // RL11
    sci_set[`UCSE_BIT_GUARD_FLAG] = tmr_zero[0]; // RL14
    sci_set[`UCSE_BIT_WAIT_FLAG]  = tmr_zero[1]; // RL13
    sci_set[`UCSE_BIT_BLOCK_FLAG] = tmr_zero[2]; // RL12
  end

  assign sci_wr = (wr_fire & sel_sci)
                ? merge(sci_q, `UCSE_MASK_SC_EVENT_CTRL, pwdata[15:0], lo_en, hi_en)
                : sci_q;
  // a hardware set in the same cycle as a software clear wins
  assign sci_d  = sci_wr | sci_set; // RL16

  // ----------------------------------------
  // wake-up and auto-baud
  // ----------------------------------------
  logic       rx_meta_q;
  logic       rx_sync_q;
  logic       rx_prev_q;
  logic       rx_fall;
  logic [2:0] abd_edges_q;
  logic       abd_done;
  ucse_reg_t  int_q;
  ucse_reg_t  int_d;
  ucse_reg_t  int_set;

  assign rx_fall  = rx_prev_q & ~rx_sync_q;
  // the fifth falling edge of the sync character ends the sequence
  assign abd_done = autobaud_enable & rx_fall &
                    (abd_edges_q == `UCSE_ABD_FALL_EDGES - 3'h1); // RL18

  always_comb begin
    int_set = 16'h0000;
    int_set[`UCSE_BIT_WAKE_FLAG] = wake_enable & rx_fall; // RL17
    int_set[`UCSE_BIT_ABD_FLAG]  = abd_done;              // RL18
  end

  assign int_d = ((wr_fire & sel_int)
               ? merge(int_q, `UCSE_MASK_WAKE_ABD_CTRL, pwdata[15:0], lo_en, hi_en)
               : int_q) | int_set; // RL16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q   <= 1'b1;
      rx_sync_q   <= 1'b1;
      rx_prev_q   <= 1'b1;
      abd_edges_q <= 3'h0;
      sci_q       <= `UCSE_RESET_VALUE; // RL20
      int_q       <= `UCSE_RESET_VALUE; // RL20
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
      sci_q     <= sci_d;
      int_q     <= int_d;
      if (!autobaud_enable | abd_done) begin
        abd_edges_q <= 3'h0;
      end else if (rx_fall) begin
        abd_edges_q <= abd_edges_q + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // read mux and registered outputs
  // ----------------------------------------
  always_comb begin
    rdata_mux = 16'h0000; // RL20
    if (sel_chk) begin
      rdata_mux = {8'h00, chk_q};
    end
    if (sel_cfg) begin
      rdata_mux = cfg_q;
    end
    if (sel_sci) begin
      rdata_mux = sci_q;
    end
    if (sel_int) begin
      rdata_mux = int_q;
    end
  end

  logic sc_irq_q;
  logic ev_irq_q;
  logic logic_convention_select_q;
  logic prot_q;
  logic pd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_irq_q <= 1'b0;
      ev_irq_q <= 1'b0;
      logic_convention_select_q   <= 1'b0;
      prot_q   <= 1'b0;
      pd_q     <= 1'b0;
    end else begin
      sc_irq_q <= |(sci_d[13:8] & sci_d[5:0]); // RL15
      ev_irq_q <= int_d[`UCSE_BIT_WAKE_FLAG] |
                  (int_d[`UCSE_BIT_ABD_FLAG] & int_d[`UCSE_BIT_ABD_ENABLE]); // RL19
      logic_convention_select_q   <= cfg_d_logic_convention_select(cfg_q); // RL7
      prot_q   <= cfg_q[`UCSE_BIT_PROTOCOL]; // RL9
      pd_q     <= (pd_left_q != 2'h0) | pd_start; // RL8
    end
  end

  function automatic logic cfg_d_logic_convention_select(input ucse_reg_t c);
    cfg_d_logic_convention_select = c[`UCSE_BIT_LOGIC_CONVENTION_SELECT];
  endfunction

  assign smart_card_irq           = sc_irq_q;
  assign event_irq                = ev_irq_q;
  assign logic_convention_inverse = logic_convention_select_q;
  assign card_protocol_t1         = prot_q;
  assign card_line_pulldown       = pd_q;
  assign tx_retransmit            = tx_retransmit_q;

endmodule
`default_nettype wire

// ==== verification/ucse_properties.sv ====
/*
  port-level checker for the checksum and card event block.
  sees only the top module's ports; bound to every ucse_top.
*/
`timescale 1ns/10ps
`default_nettype none
module ucse_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_char_done,
  input wire logic        rx_parity_error,
  input wire logic        tx_char_done,
  input wire logic        tx_line_error,
  input wire logic        wake_enable,
  input wire logic        rx_pin,
  input wire logic        tx_retransmit,
  input wire logic        card_line_pulldown,
  input wire logic        logic_convention_inverse,
  input wire logic        card_protocol_t1,
  input wire logic        event_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic unmapped = (paddr[11:4] != 8'h00) || (paddr[1:0] != 2'h0);
  wire logic cfg_wr = psel && penable && pready && pwrite && !pslverr
                      && paddr == 12'h004 && pstrb[0];
  chk_ready_one_cycle: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  chk_slverr_map: assert property (
    pready |-> pslverr == unmapped)
    else $error("pslverr does not match address map");
  chk_read_zeroes: assert property (
    pready && !pwrite |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0))
    else $error("read data has bits outside the register");
  chk_logic_convention_select_copy: assert property (
    cfg_wr |-> ##2 logic_convention_inverse == $past(pwdata[3], 2))
    else $error("convention output wrong");
  chk_proto_copy: assert property (
    cfg_wr |-> ##2 card_protocol_t1 == $past(pwdata[1], 2))
    else $error("protocol output wrong");
  chk_pulldown_cause: assert property (
    $rose(card_line_pulldown) |-> $past(rx_char_done && rx_parity_error))
    else $error("pulldown without error char");
  chk_retx_pulse: assert property (
    tx_retransmit |-> $past(tx_char_done && tx_line_error) ##1 !tx_retransmit)
    else $error("retransmit pulse wrong");
  chk_wake_irq: assert property (
    wake_enable && $fell(rx_pin) |-> ##[3:6] event_irq)
    else $error("wake edge gave no event irq");
endmodule

bind ucse_top ucse_properties ucse_properties_i (.*);
`default_nettype wire

// ==== verification/ucse_line_model.sv ====
/*
  far-side line model: makes high-to-low edges on the receive line.
  the line idles high as a pulled-up serial line does.
*/
`timescale 1ns/10ps
`default_nettype none
module ucse_line_model (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [2:0] falls,
  output var  logic       rx_pin,
  output var  logic       busy
);
  initial begin
    rx_pin = 1'b1;
    busy = 1'b0;
  end
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < falls; i++) begin
        repeat (2) @(posedge pclk);
        rx_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        rx_pin <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  self-checking bench: apb master, event pulses, line model.
  assumes design, constants header and checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se, rt, go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, nrt;
  logic [3:0]  pstrb;
  logic        lin_mode, lin_slave_mode, checksum_include_select, smart_card_mode;
  logic [7:0]  rx_byte;
  logic        rx_byte_is_pid, rx_parity_error, tx_line_error, wake_enable, autobaud_enable;
  logic [2:0]  timer_start, falls;
  logic [23:0] guard_load, block_load, waiting_load;
  logic        rx_pin, tx_retransmit, card_line_pulldown, logic_convention_inverse;
  logic        card_protocol_t1, smart_card_irq, event_irq;
  logic [4:0]  ev;
  wire logic   break_detect, rx_byte_valid, rx_char_done, tx_char_done, etu_tick;
  int          n_errors, tests_run, sum;
  // register model: offsets and implemented bits
  logic [11:0] ofs[4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
  logic [15:0] msk[4] = '{16'h00FF, 16'h003E, 16'h3737, 16'h00C4};
  logic [15:0] tbit[3] = '{16'h0100, 16'h0200, 16'h0400};
  assign {break_detect, rx_byte_valid, rx_char_done, tx_char_done, etu_tick} = ev;
  ucse_top #(.TIMER_W(24)) ucse_top_i (.*);
  ucse_line_model ucse_line_model_i (.*);
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    if (pready !== 1'b1) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] w);
    apb(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, w});
  endtask
  // pulses one event for one cycle; samples the retransmit output after it
  task automatic pulse(input logic [4:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 5'h00;
    @(posedge pclk);
    rt = tx_retransmit;
  endtask
  task automatic line(input logic [2:0] n);
    int k;
    k = 0;
    falls <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy !== 1'b0 && k < 99);
    if (busy !== 1'b0) n_errors++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, go, lin_mode, lin_slave_mode} = '0;
    {checksum_include_select, smart_card_mode, rx_byte_is_pid, rx_parity_error} = '0;
    {tx_line_error, wake_enable, autobaud_enable, ev, timer_start, falls} = '0;
    {paddr, pwdata, rx_byte, guard_load, block_load, waiting_load} = '0;
    pstrb = 4'hF;
    seed = 32'hB3C2;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) begin
      rdc(ofs[i], 16'h0000);
      apb(1'b1, ofs[i], 16'hFFFF);
      rdc(ofs[i], msk[i]);
    end
    chk({logic_convention_inverse, card_protocol_t1, smart_card_irq, event_irq}, 4'hF);
    apb(1'b1, 12'h008, 16'h3700);
    apb(1'b1, 12'h004, 16'h0008);
    repeat (2) @(posedge pclk);
    chk({logic_convention_inverse, card_protocol_t1, smart_card_irq}, 3'h4);
    apb(1'b0, 12'h010, 16'h0000);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
    foreach (ofs[i]) apb(1'b1, ofs[i], 16'h0000);
    $display("registers done");
    for (int m = 0; m < 4; m++) begin
      lin_mode <= m[1];
      lin_slave_mode <= m[1];
      checksum_include_select <= m[0];
      seed = lfsr(seed);
      sum = seed[7:0];
      apb(1'b1, 12'h000, {8'h00, seed[7:0]});
      for (int k = 0; k < 5; k++) begin
        seed = lfsr(seed);
        rx_byte <= seed[7:0];
        rx_byte_is_pid <= (k == 0);
        pulse(5'h08);
        if (m[0] || (m[1] && k > 0)) sum = sum + seed[7:0];
        if (sum > 255) sum = sum - 255;
      end
      rdc(12'h000, sum[15:0]);
      if (m[1]) begin
        lin_slave_mode <= 1'b0;
        pulse(5'h10);
        rdc(12'h000, sum[15:0]);
        lin_slave_mode <= 1'b1;
        pulse(5'h10);
        rdc(12'h000, 16'h0000);
      end
    end
    $display("checksum done");
    smart_card_mode <= 1'b1;
    tx_line_error <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 12'h004, {10'h000, r[1:0], 4'h0});
      nrt = '0;
      for (int k = 0; k <= r; k++) begin
        pulse(5'h02);
        nrt = nrt + rt;
      end
      rdc(12'h008, 16'h0000);
      pulse(5'h02);
      chk(nrt + rt, r + 1);
      rdc(12'h008, 16'h1000);
      apb(1'b1, 12'h008, 16'h0000);
    end
    rx_parity_error <= 1'b1;
    repeat (4) pulse(5'h04);
    rx_parity_error <= 1'b0;
    pulse(5'h04);
    rx_parity_error <= 1'b1;
    repeat (4) pulse(5'h04);
    rdc(12'h008, 16'h0000);
    pulse(5'h04);
    rdc(12'h008, 16'h2000);
    chk(smart_card_irq, 1'b0);
    apb(1'b1, 12'h008, 16'h2020);
    repeat (2) @(posedge pclk);
    chk(smart_card_irq, 1'b1);
    apb(1'b1, 12'h008, 16'h0000);
    chk(card_line_pulldown, 1'b1);
    pulse(5'h01);
    @(posedge pclk);
    chk(card_line_pulldown, 1'b0);
    apb(1'b1, 12'h004, 16'h0004);
    pulse(5'h04);
    pulse(5'h01);
    @(posedge pclk);
    chk(card_line_pulldown, 1'b1);
    pulse(5'h01);
    @(posedge pclk);
    chk(card_line_pulldown, 1'b0);
    apb(1'b1, 12'h004, 16'h0006);
    pulse(5'h04);
    @(posedge pclk);
    chk(card_line_pulldown, 1'b0);
    rx_parity_error <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      guard_load <= 24'(i + 2);
      block_load <= 24'(i + 2);
      waiting_load <= 24'(i + 2);
      timer_start <= 3'(1 << i);
      @(posedge pclk);
      timer_start <= 3'h0;
      repeat (i + 1) pulse(5'h01);
      rdc(12'h008, 16'h0000);
      pulse(5'h01);
      rdc(12'h008, tbit[i]);
      apb(1'b1, 12'h008, 16'h0000);
    end
    $display("card events done");
    wake_enable <= 1'b1;
    line(3'h1);
    rdc(12'h00C, 16'h0080);
    chk(event_irq, 1'b1);
    apb(1'b1, 12'h00C, 16'h0000);
    wake_enable <= 1'b0;
    autobaud_enable <= 1'b1;
    line(3'h4);
    rdc(12'h00C, 16'h0000);
    line(3'h1);
    rdc(12'h00C, 16'h0040);
    chk(event_irq, 1'b0);
    apb(1'b1, 12'h00C, 16'h0044);
    repeat (2) @(posedge pclk);
    chk(event_irq, 1'b1);
    $display("wake and autobaud done");
    report_and_stop();
  end
endmodule
`default_nettype wire
